// ---- token_bus_diag_pkg.sv ----
package token_bus_diag_pkg;

  // ************************************************************
  // register map, byte addresses on the 32-bit bus
  // ************************************************************
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] DIAG_OFF   = 8'h04;
  localparam logic [7:0] CMD_OFF    = 8'h08;
  localparam logic [7:0] SETUP_OFF  = 8'h0c;
  localparam logic [7:0] CONFIG_OFF = 8'h10;
  localparam logic [7:0] NODE_OFF   = 8'h14;
  localparam logic [7:0] TENT_OFF   = 8'h18;
  localparam logic [7:0] SUCC_OFF   = 8'h1c;

  // ************************************************************
  // field positions
  // ************************************************************
  // status register
  localparam int ST_TXAV  = 0;
  localparam int ST_TXACK = 1;
  localparam int ST_EXNK  = 2;
  localparam int ST_RECON = 3;
  localparam int ST_SUCC  = 4;
  localparam int ST_RXINH = 5;
  localparam int ST_MAPDN = 6;
  // diagnostic register
  localparam int DG_DUP   = 0;
  localparam int DG_TENT  = 1;
  // command register, write one to act
  localparam int CM_DISTX = 0;
  localparam int CM_CLRFL = 1;
  localparam int CM_ENTX  = 2;
  localparam int CM_CLRTN = 3;
  // setup and configuration
  localparam int SU_SHORT = 0;
  localparam int CF_CHAIN = 0;

  // ************************************************************
  // reset values and limits
  // ************************************************************
  localparam logic [7:0] NODE_RST      = 8'h00;
  localparam logic [7:0] TENT_RST      = 8'h00;
  localparam logic [7:0] SUCC_RST      = 8'h00;
  localparam logic [7:0] NACK_LIMIT    = 8'h80;  // 128 negative enquiry replies
  localparam logic [7:0] NACK_LIMIT_SH = 8'h04;  // four with short select
  localparam logic [1:0] QUEUE_MAX     = 2'h2;   // chained commands
  localparam logic [1:0] QUEUE_ONE     = 2'h1;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_MHZ        = 200;
  localparam int MAP_WAIT_MS    = 840;
  localparam int MAP_WAIT_CYCLES = MAP_WAIT_MS * 1000 * CLK_MHZ;
  localparam int MAP_CNT_W      = 28;

  // transmit sequencer states
  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_BUSY = 2'b10
  } tx_state_t;

endpackage : token_bus_diag_pkg

// ---- nack_retry_counter.sv ----
`timescale 1ns/1ps
module nack_retry_counter
  import token_bus_diag_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic restart_i,
  input  wire logic nack_i,
  input  wire logic short_limit_i,
  output logic      limit_hit_o,
  output logic [7:0] count_o
);

  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [7:0] limit;
  logic       at_last;

  // ************************************************************
  // threshold and next count
  // ************************************************************
  assign limit       = short_limit_i ? NACK_LIMIT_SH : NACK_LIMIT;
  assign at_last     = (count_ff == limit - 8'h01);
  assign limit_hit_o = nack_i && at_last && !restart_i;
  // saturate at the limit; further enquiries keep going upstream
  assign nxt_count   = restart_i ? 8'h00 :
                       (nack_i && count_ff < limit) ? count_ff + 8'h01 : count_ff;
  assign count_o     = count_ff;

  // count register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= 8'h00;
    else
      count_ff <= nxt_count;
  end

endmodule : nack_retry_counter

// ---- token_bus_diagnostics.sv ----
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
// What this block does
// - count negative enquiry replies, flag at 128
// - short select lowers threshold to four
// - unavailable receiver answer counts as failed attempt
// - enquiries continue after threshold until software acts
// - disable transmitter command aborts pending transmission
// - only clear flags command clears excessive flag
// - duplicate flag on answer to own-ID token
// - diagnostic status read clears duplicate flag
// - tentative ID register, match bit on activity
// - no tentative match while sending the token
// - readable successor ID register
// - successor change event on every successor update
// - node ID write then 840ms wait maps
// - transmission end sets available flag, loads acknowledge flag from the reply
// - chaining bit allows two queued transmit commands
// - merge five event flags into one request
module token_bus_diagnostics
  import token_bus_diag_pkg::*;
#(
  parameter int unsigned MAP_WAIT_CYC = MAP_WAIT_CYCLES
)
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic             ack_o,
  // protocol engine side
  input  wire logic        fbe_nack_i,
  input  wire logic        tx_done_i,
  input  wire logic        tx_ack_ok_i,
  input  wire logic        token_rx_i,
  input  wire logic [7:0]  token_dst_id_i,
  input  wire logic        line_act_i,
  input  wire logic [7:0]  line_src_id_i,
  input  wire logic        token_tx_i,
  input  wire logic        succ_update_i,
  input  wire logic [7:0]  succ_id_i,
  input  wire logic        recon_i,
  input  wire logic        rx_inhibit_i,
  output logic             tx_start_o,
  output logic             tx_abort_o,
  output logic             fbe_retry_o,
  output logic [7:0]       node_id_o,
  output logic             irq_o
);

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit
  // ************************************************************
  // bus decode
  // ************************************************************
  logic ack_ff;
  logic acc;
  logic wr;
  logic rd;
  logic wr_cmd;
  logic wr_setup;
  logic wr_cfg;
  logic wr_node;
  logic wr_tent;
  logic rd_diag;
  assign acc      = cyc_i && stb_i && !ack_ff;
  assign wr       = acc && we_i && sel_i[0];
  assign rd       = acc && !we_i;
  assign wr_cmd   = wr && hit(adr_i, CMD_OFF);
  assign wr_setup = wr && hit(adr_i, SETUP_OFF);
  assign wr_cfg   = wr && hit(adr_i, CONFIG_OFF);
  assign wr_node  = wr && hit(adr_i, NODE_OFF);
  assign wr_tent  = wr && hit(adr_i, TENT_OFF);
  assign rd_diag  = rd && hit(adr_i, DIAG_OFF);
  assign ack_o    = ack_ff;
  // command strobes
  logic cmd_dis;
  logic cmd_clr;
  logic cmd_entx;
  logic cmd_clrtn;
  assign cmd_dis   = wr_cmd && dat_i[CM_DISTX];
  assign cmd_clr   = wr_cmd && dat_i[CM_CLRFL];
  assign cmd_entx  = wr_cmd && dat_i[CM_ENTX];
  assign cmd_clrtn = wr_cmd && dat_i[CM_CLRTN];

  // ************************************************************
  // control registers
  // ************************************************************
  logic       short_ff;
  logic       chain_ff;
  logic [7:0] node_ff;
  logic [7:0] tent_ff;
  logic [7:0] succ_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      short_ff <= 1'b0;
      chain_ff <= 1'b0;
      node_ff  <= NODE_RST;
      tent_ff  <= TENT_RST;
    end
    else
    begin
      if (wr_setup) short_ff <= dat_i[SU_SHORT];
      if (wr_cfg)   chain_ff <= dat_i[CF_CHAIN];
      if (wr_node)  node_ff  <= dat_i[7:0];
      if (wr_tent)  tent_ff  <= dat_i[7:0];
    end
  end
  // successor id follows the engine's updates
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      succ_ff <= SUCC_RST;
    else if (succ_update_i)
      succ_ff <= succ_id_i;
  end
  assign node_id_o = node_ff;
  // ************************************************************
  // transmit queue and sequencer
  // ************************************************************
  tx_state_t  state_ff;
  tx_state_t  nxt_state;
  logic [1:0] queue_ff;
  logic [1:0] nxt_queue;
  logic       room;
  logic       accept;
  logic       launch;
  // without chaining only one command may be outstanding
  assign room    = chain_ff ? (queue_ff < QUEUE_MAX) : (queue_ff == 2'h0);
  assign accept  = cmd_entx && room && !cmd_dis;
  assign launch  = (state_ff == TX_IDLE) && (queue_ff != 2'h0) && !cmd_dis;
  always_comb
  begin
    nxt_state = state_ff;
    nxt_queue = queue_ff;
    if (cmd_dis)
    begin
      nxt_state = TX_IDLE;
      nxt_queue = 2'h0;
    end
    else
    begin
      case (state_ff)
        TX_IDLE:
          if (launch)
            nxt_state = TX_BUSY;
        TX_BUSY:
          if (tx_done_i)
          begin
            nxt_state = TX_IDLE;
            nxt_queue = queue_ff - QUEUE_ONE;
          end
        default:
          nxt_state = TX_IDLE;
      endcase
      if (accept)
        nxt_queue = nxt_queue + QUEUE_ONE;
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= TX_IDLE;
      queue_ff <= 2'h0;
    end
    else
    begin
      state_ff <= nxt_state;
      queue_ff <= nxt_queue;
    end
  end
  // engine control pulses from flops
  logic start_ff;
  logic abort_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_ff <= 1'b0;
      abort_ff <= 1'b0;
    end
    else
    begin
      start_ff <= launch;
      abort_ff <= cmd_dis && (state_ff == TX_BUSY || queue_ff != 2'h0);
    end
  end
  assign tx_start_o  = start_ff;
  assign tx_abort_o  = abort_ff;
  assign fbe_retry_o = (state_ff == TX_BUSY);

  // ************************************************************
  // excessive negative acknowledge
  // ************************************************************
  logic       nack_hit;
  logic       busy_nack;
  assign busy_nack = fbe_nack_i && (state_ff == TX_BUSY);
  nack_retry_counter nack_retry_counter_i (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .restart_i    (launch || cmd_dis),
    .nack_i       (busy_nack),
    .short_limit_i(short_ff),
    .limit_hit_o  (nack_hit),
    .count_o      ()
  );

  // ************************************************************
  // detectors
  // ************************************************************
  logic armed_ff;
  logic dup_set;
  logic tent_set;
  // arm on a token for our own id, fire on the activity answering it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      armed_ff <= 1'b0;
    else if (token_rx_i)
      armed_ff <= (token_dst_id_i == node_ff);
    else if (line_act_i)
      armed_ff <= 1'b0;
  end
  assign dup_set  = armed_ff && line_act_i && !token_rx_i;
  assign tent_set = line_act_i && !token_tx_i && (line_src_id_i == tent_ff);
  // ************************************************************
  // sticky flags, set wins over clear
  // ************************************************************
  logic txav_ff;
  logic txack_ff;
  logic exnk_ff;
  logic recon_ff;
  logic succ_ch_ff;
  logic dup_ff;
  logic tentm_ff;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      txav_ff    <= 1'b1;
      txack_ff   <= 1'b0;
      exnk_ff    <= 1'b0;
      recon_ff   <= 1'b0;
      succ_ch_ff <= 1'b0;
      dup_ff     <= 1'b0;
      tentm_ff   <= 1'b0;
    end
    else
    begin
      txav_ff    <= (state_ff == TX_BUSY && tx_done_i) || cmd_dis || (txav_ff && !accept);
      txack_ff   <= (state_ff == TX_BUSY && tx_done_i) ? tx_ack_ok_i : (txack_ff && !accept);
      exnk_ff    <= nack_hit || (exnk_ff && !cmd_clr);
      recon_ff   <= recon_i || (recon_ff && !cmd_clr);
      succ_ch_ff <= succ_update_i || (succ_ch_ff && !cmd_clr);
      dup_ff     <= dup_set || (dup_ff && !rd_diag);
      tentm_ff   <= tent_set || (tentm_ff && !cmd_clrtn && !wr_tent);
    end
  end
  // merged request to the processor
  assign irq_o = rx_inhibit_i || txav_ff || exnk_ff || recon_ff || succ_ch_ff;
  // ************************************************************
  // off-line mapping wait
  // ************************************************************
  logic [MAP_CNT_W-1:0] map_cnt_ff;
  logic                 map_run_ff;
  logic                 map_done_ff;
  // writing a candidate node id starts the settle wait
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      map_cnt_ff  <= '0;
      map_run_ff  <= 1'b0;
      map_done_ff <= 1'b0;
    end
    else if (wr_node)
    begin
      map_cnt_ff  <= MAP_CNT_W'(MAP_WAIT_CYC - 1);
      map_run_ff  <= 1'b1;
      map_done_ff <= 1'b0;
    end
    else if (map_run_ff)
    begin
      if (map_cnt_ff == '0)
      begin
        map_run_ff  <= 1'b0;
        map_done_ff <= 1'b1;
      end
      else
        map_cnt_ff <= map_cnt_ff - 1'b1;
    end
  end
  // ************************************************************
  // read data and acknowledge
  // ************************************************************
  logic [7:0] rd_byte;
  logic [7:0] status_byte;
  logic [7:0] diag_byte;
  assign status_byte = {1'b0, map_done_ff, rx_inhibit_i, succ_ch_ff, recon_ff, exnk_ff, txack_ff, txav_ff};
  assign diag_byte   = {6'h00, tentm_ff, dup_ff};
  assign rd_byte     = hit(adr_i, STATUS_OFF) ? status_byte :
                       hit(adr_i, DIAG_OFF)   ? diag_byte :
                       hit(adr_i, SETUP_OFF)  ? {7'h00, short_ff} :
                       hit(adr_i, CONFIG_OFF) ? {7'h00, chain_ff} :
                       hit(adr_i, NODE_OFF)   ? node_ff :
                       hit(adr_i, TENT_OFF)   ? tent_ff :
                       hit(adr_i, SUCC_OFF)   ? succ_ff : 8'h00;
  // one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      dat_o  <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= acc;
      if (rd)
        dat_o <= {24'h00_0000, rd_byte};
    end
  end
endmodule : token_bus_diagnostics

// ---- token_bus_diagnostics_properties.sv ----
`timescale 1ns/1ps
module token_bus_diagnostics_properties
  import token_bus_diag_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_i,
  input wire logic        we_i,
  input wire logic [3:0]  sel_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        tx_done_i,
  input wire logic        rx_inhibit_i,
  input wire logic        tx_start_o,
  input wire logic        tx_abort_o,
  input wire logic        fbe_retry_o,
  input wire logic [7:0]  node_id_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // decode of the access taken at this edge
  wire take = cyc_i & stb_i & ~ack_o;
  wire wr0  = take & we_i & sel_i[0];
  wire cmd  = wr0 & (adr_i[7:2] == CMD_OFF[7:2]);
  wire nwr  = wr0 & (adr_i[7:2] == NODE_OFF[7:2]);
  property p_ack; take |=> ack_o ##1 !ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  property p_abort; cmd & dat_i[CM_DISTX] & fbe_retry_o |=> tx_abort_o && !fbe_retry_o; endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  property p_cause; tx_abort_o |-> $past(cmd & dat_i[CM_DISTX]); endproperty
  a_cause: assert property (p_cause) else $error("stray abort");
  property p_done; tx_done_i & fbe_retry_o |=> !fbe_retry_o && irq_o; endproperty
  a_done: assert property (p_done) else $error("done not seen");
  property p_start; tx_start_o |-> fbe_retry_o ##1 !tx_start_o; endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_rxinh; rx_inhibit_i |-> irq_o; endproperty
  a_rxinh: assert property (p_rxinh) else $error("irq missing");
  property p_node; nwr |=> node_id_o == $past(dat_i[7:0]); endproperty
  a_node: assert property (p_node) else $error("node id");
  property p_stay; fbe_retry_o & !tx_done_i & !cmd |=> fbe_retry_o; endproperty
  a_stay: assert property (p_stay) else $error("retry dropped");
endmodule : token_bus_diagnostics_properties

bind token_bus_diagnostics token_bus_diagnostics_properties token_bus_diagnostics_properties_i (
  .clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .tx_done_i,
  .rx_inhibit_i, .tx_start_o, .tx_abort_o, .fbe_retry_o, .node_id_o, .irq_o);

// ---- token_bus_peer_model.sv ----
`timescale 1ns/1ps
module token_bus_peer_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       abort_i,
  input  wire logic [7:0] nacks_i,
  input  wire logic [7:0] dly_i,
  input  wire logic       ack_i,
  output logic            fbe_nack_o,
  output logic            tx_done_o,
  output logic            tx_ack_ok_o
);
  logic       busy_ff;
  logic       tgl_ff;
  logic [7:0] cnt_ff;
  logic [7:0] gap_ff;
  // one gap counter paces every answer; nacks_i of ff never gives up
  always_ff @(posedge clk_i)
  begin
    fbe_nack_o <= 1'b0;
    tx_done_o  <= 1'b0;
    tgl_ff     <= rst_i ? 1'b0 : ~tgl_ff;
    if (rst_i || abort_i)
      busy_ff <= 1'b0;
    else if (start_i)
    begin
      busy_ff <= 1'b1;
      cnt_ff  <= 8'h00;
      gap_ff  <= dly_i;
    end
    else if (busy_ff && gap_ff != 8'h00)
      gap_ff <= gap_ff - 8'h01;
    else if (busy_ff && cnt_ff == nacks_i)
    begin
      tx_done_o <= 1'b1;
      busy_ff   <= 1'b0;
    end
    else if (busy_ff)
    begin
      fbe_nack_o <= 1'b1;
      gap_ff     <= dly_i;
      cnt_ff     <= cnt_ff + {7'h00, nacks_i != 8'hff};
    end
  end
  // acknowledge level is only meaningful with done, else it toggles
  assign tx_ack_ok_o = tx_done_o ? ack_i : tgl_ff;
endmodule : token_bus_peer_model

// ---- token_bus_diagnostics_tb_top.sv ----
`timescale 1ns/1ps
module token_bus_diagnostics_tb_top import token_bus_diag_pkg::*;;
  logic        clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, ack_ok, fbe_nack_i, tx_done_i, tx_ack_ok_i;
  logic        token_rx_i, line_act_i, token_tx_i, succ_update_i, recon_i, rx_inhibit_i;
  logic        tx_start_o, tx_abort_o, fbe_retry_o, irq_o;
  logic [7:0]  adr_i, token_dst_id_i, line_src_id_i, succ_id_i, node_id_o, nacks, dly, v;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, exp_q[$], msk_q[$];
  int          n_mismatch, n_compared, n_start, n_done, n_nack, n_abort, i, b, lim;
  token_bus_diagnostics #(.MAP_WAIT_CYC(20)) token_bus_diagnostics_i (.clk_i, .rst_i, .adr_i, .dat_i,
    .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .fbe_nack_i, .tx_done_i, .tx_ack_ok_i, .token_rx_i,
    .token_dst_id_i, .line_act_i, .line_src_id_i, .token_tx_i, .succ_update_i, .succ_id_i, .recon_i,
    .rx_inhibit_i, .tx_start_o, .tx_abort_o, .fbe_retry_o, .node_id_o, .irq_o);
  token_bus_peer_model token_bus_peer_model_i (.clk_i, .rst_i, .start_i(tx_start_o),
    .abort_i(tx_abort_o), .nacks_i(nacks), .dly_i(dly), .ack_i(ack_ok), .fbe_nack_o(fbe_nack_i),
    .tx_done_o(tx_done_i), .tx_ack_ok_o(tx_ack_ok_i));
  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  // read data against the oldest note, event counters
  always @(posedge clk_i)
  begin
    if (ack_o === 1'b1 && we_i === 1'b0)
      chk(dat_o & msk_q.pop_front(), exp_q.pop_front());
    if (tx_start_o === 1'b1) n_start++;
    if (tx_done_i === 1'b1) n_done++;
    if (fbe_nack_i === 1'b1) n_nack++;
    if (tx_abort_o === 1'b1) n_abort++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test
  task automatic tout();
    n_mismatch++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 0, 1);
    stop_test();
  endtask : tout
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int k;
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    sel_i <= s;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    if (k == 50) tout();
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    msk_q.push_back(m);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0, 4'hf);
  endtask : rd
  task automatic till(ref int c, input int n);
    int k;
    for (k = 0; k < 5000 && c < n; k++) @(posedge clk_i);
    if (c < n) tout();
  endtask : till
  // token (optional) then line activity from src
  task automatic net(input logic t, input logic [7:0] dst, input logic [7:0] src);
    @(posedge clk_i);
    token_rx_i     <= t;
    token_dst_id_i <= dst;
    @(posedge clk_i);
    token_rx_i    <= 1'b0;
    line_act_i    <= 1'b1;
    line_src_id_i <= src;
    @(posedge clk_i);
    line_act_i <= 1'b0;
  endtask : net
  task automatic evt(input logic s, input logic r);
    @(posedge clk_i);
    succ_update_i <= s;
    recon_i       <= r;
    @(posedge clk_i);
    succ_update_i <= 1'b0;
    recon_i       <= 1'b0;
  endtask : evt
  initial
  begin
    {we_i, cyc_i, stb_i, token_rx_i, line_act_i, token_tx_i, succ_update_i, recon_i} = '0;
    {adr_i, dat_i, sel_i, token_dst_id_i, line_src_id_i, succ_id_i, rx_inhibit_i} = '0;
    {n_mismatch, n_compared, n_start, n_done, n_nack, n_abort} = '0;
    {nacks, dly, ack_ok} = '0;
    rst_i = 1'b1;
    i = $urandom(32'h85b7);
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(STATUS_OFF, 32'h3f, 32'h1);
    for (i = 1; i < 8; i++) if (i != 2) rd(8'(i * 4), 32'hffffffff, 32'h0);
    rd(8'h40, 32'hffffffff, 32'h0);
    $display("test reset done");
    v = 8'($urandom());
    wr(NODE_OFF, {24'h0, v});
    rd(STATUS_OFF, 32'h40, 32'h0);
    chk({24'h0, node_id_o}, {24'h0, v});
    bus(NODE_OFF, 1'b1, {24'h0, ~v}, 4'he);
    wr(SUCC_OFF, 32'h5a);
    wr(8'h40, 32'h5a);
    rd(NODE_OFF, 32'hff, {24'h0, v});
    rd(SUCC_OFF, 32'hff, 32'h0);
    net(1'b1, v, ~v);
    rd(DIAG_OFF, 32'h1, 32'h1);
    rd(DIAG_OFF, 32'h1, 32'h0);
    net(1'b1, ~v, v);
    rd(DIAG_OFF, 32'h1, 32'h0);
    repeat (20) @(posedge clk_i);
    rd(STATUS_OFF, 32'h40, 32'h40);
    $display("test map done");
    v = 8'($urandom());
    wr(TENT_OFF, {24'h0, v});
    token_tx_i <= 1'b1;
    net(1'b0, 8'h0, v);
    rd(DIAG_OFF, 32'h2, 32'h0);
    token_tx_i <= 1'b0;
    net(1'b0, 8'h0, v);
    rd(DIAG_OFF, 32'h2, 32'h2);
    wr(CMD_OFF, 32'h8);
    rd(DIAG_OFF, 32'h2, 32'h0);
    succ_id_i <= 8'($urandom());
    evt(1'b1, 1'b0);
    rd(SUCC_OFF, 32'hff, {24'h0, succ_id_i});
    rd(STATUS_OFF, 32'h18, 32'h10);
    evt(1'b0, 1'b1);
    rd(STATUS_OFF, 32'h18, 32'h18);
    wr(CMD_OFF, 32'h2);
    rd(STATUS_OFF, 32'h18, 32'h0);
    $display("test ids done");
    for (i = 0; i < 2; i++)
    begin
      ack_ok <= ~i[0];
      nacks  <= 8'h2;
      dly    <= 8'(4 + $urandom() % 8);
      wr(CMD_OFF, 32'h4);
      rx_inhibit_i <= 1'b1;
      rd(STATUS_OFF, 32'h23, 32'h20);
      chk({31'h0, irq_o}, 32'h1);
      rx_inhibit_i <= 1'b0;
      @(posedge clk_i);
      chk({31'h0, irq_o}, 32'h0);
      till(n_done, i + 1);
      rd(STATUS_OFF, 32'h3, {30'h0, ~i[0], 1'b1});
    end
    $display("test transmit done");
    for (i = 0; i < 2; i++)
    begin
      lim = i ? 4 : 128;
      wr(SETUP_OFF, i);
      nacks <= 8'hff;
      dly   <= 8'h8;
      b = n_nack;
      wr(CMD_OFF, 32'h4);
      till(n_nack, b + lim - 1);
      rd(STATUS_OFF, 32'h4, 32'h0);
      till(n_nack, b + lim);
      rd(STATUS_OFF, 32'h4, 32'h4);
      till(n_nack, b + lim + 1);
      chk({31'h0, fbe_retry_o}, 32'h1);
      wr(CMD_OFF, 32'h1);
      chk({31'h0, fbe_retry_o}, 32'h0);
      rd(STATUS_OFF, 32'h5, 32'h5);
      chk(32'(n_abort), 32'(i + 1));
      wr(CMD_OFF, 32'h2);
      rd(STATUS_OFF, 32'h4, 32'h0);
    end
    $display("test nack done");
    for (i = 0; i < 2; i++)
    begin
      wr(CONFIG_OFF, i);
      nacks <= 8'h1;
      dly   <= 8'h28;
      b = n_start;
      lim = n_done;
      repeat (2) wr(CMD_OFF, 32'h4);
      till(n_done, lim + i + 1);
      repeat (4) @(posedge clk_i);
      chk(32'(n_start - b), 32'(i + 1));
    end
    $display("test chain done");
    stop_test();
  end
endmodule : token_bus_diagnostics_tb_top
